// ### inc/capture_regs.svh
// named constants for the serial capture and storage block
// assumes a 250 MHz clk and a classic Wishbone master with 32-bit data
`ifndef CAPTURE_REGS_SVH
`define CAPTURE_REGS_SVH

`define CLK_HZ           250000000
`define BAUD_300         300
`define BAUD_1200        1200
`define BAUD_9600        9600
`define BAUD_76800       76800
`define AUTO_DECIDE_BITS 20'd4

`define ADDR_W           12
`define MEM_DEPTH        4096
`define ARRAY_LAST       7'd99
`define ERR_W            8

`define ADR_CTRL         8'h00
`define ADR_STATUS       8'h04
`define ADR_CMD          8'h08
`define ADR_DISP         8'h0C
`define ADR_WPTR         8'h10
`define ADR_DUMPPTR      8'h14
`define ADR_DUMPDATA     8'h18

`define CTRL_RESET       4'hC
`define CTRL_ENC         3
`define CMD_MARK         0
`define CMD_DUMP         1
`define CMD_RESUME       2
`define CMD_WAKE         3

`define PIN_LINE         0
`define PIN_GATE         1
`define PIN_COMPILE      2
`define PIN_KEYPAD       3
`define SETTLE_DONE      2'd3

`endif

// ### inc/capture_pkg.sv
// types shared by the capture receiver and the storage top
// assumes capture_regs.svh for all numeric constants
package capture_pkg;

  typedef enum logic [2:0] {
    RATE_300   = 3'b000,
    RATE_1200  = 3'b001,
    RATE_9600  = 3'b010,
    RATE_76800 = 3'b011,
    RATE_AUTO  = 3'b100
  } rate_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_t;

endpackage

// ### rtl/capture_rx.sv
// asynchronous byte receiver with rate selection and 76800/9600 fallback
// assumes line and gate are already synchronised to clk
`timescale 1ns/1ps
`include "capture_regs.svh"
module capture_rx #(
  parameter logic [19:0] BIT_300   = 20'(`CLK_HZ / `BAUD_300),
  parameter logic [19:0] BIT_1200  = 20'(`CLK_HZ / `BAUD_1200),
  parameter logic [19:0] BIT_9600  = 20'(`CLK_HZ / `BAUD_9600),
  parameter logic [19:0] BIT_76800 = 20'(`CLK_HZ / `BAUD_76800)
) (
  input  wire logic           clk,
  input  wire logic           rst,
  input  wire logic           line,
  input  wire logic           gate,
  input  wire logic           standby,
  input  wire capture_pkg::rate_t rate,
  output logic                byte_valid,
  output logic [7:0]          byte_data,
  output logic                frame_err,
  output logic                fast_lock
);
  import capture_pkg::*;

  rx_state_t   state_reg;
  logic [19:0] cnt_reg;
  logic [19:0] elapsed_reg;
  logic [2:0]  idx_reg;
  logic [7:0]  shift_reg;
  logic        decided_reg;
  logic        seen_low_reg;
  logic [19:0] period;

  always_comb begin
    unique case (rate)
      RATE_300:   period = BIT_300;
      RATE_1200:  period = BIT_1200;
      RATE_9600:  period = BIT_9600;
      RATE_76800: period = BIT_76800;
      default:    period = fast_lock ? BIT_76800 : BIT_9600;
    endcase
  end

  wire logic tick    = cnt_reg == 20'h00000;
  wire logic pending = (rate == RATE_AUTO) && !decided_reg && state_reg != RX_IDLE;
  // decide once, half a 9600 bit after the first start edge
  wire logic decide  = pending && elapsed_reg == `AUTO_DECIDE_BITS * BIT_76800;

  // start high, eight data bits lsb first, stop low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg    <= RX_IDLE;
      cnt_reg      <= 20'h00000;
      elapsed_reg  <= 20'h00000;
      idx_reg      <= 3'h0;
      shift_reg    <= 8'h00;
      decided_reg  <= 1'b0;
      seen_low_reg <= 1'b0;
      fast_lock    <= 1'b1;
      byte_valid   <= 1'b0;
      byte_data    <= 8'h00;
      frame_err    <= 1'b0;
    end else begin
      byte_valid <= 1'b0;
      frame_err  <= 1'b0;
      if (!gate) begin
        // the combined mode unlocks only when the gate falls
        state_reg   <= RX_IDLE;
        decided_reg <= 1'b0;
        fast_lock   <= 1'b1;
      end else begin
        unique case (state_reg)
          RX_IDLE: begin
            // no restart during standby
            // frame_err covers the one cycle before the top raises standby
            if (line && !standby && !frame_err) begin
              state_reg    <= RX_START;
              cnt_reg      <= period >> 1;
              elapsed_reg  <= 20'h00000;
              seen_low_reg <= 1'b0;
            end
          end
          RX_START, RX_DATA, RX_STOP: begin
            elapsed_reg <= elapsed_reg + 20'h00001;
            if (!line) begin
              seen_low_reg <= 1'b1;
            end
            if (decide) begin
              decided_reg <= 1'b1;
            end
            // no low seen yet: the frame is a slow one, resync to 9600
            // a fast frame keeps counting so its sample points do not slip
            if (decide && !seen_low_reg) begin
              fast_lock <= 1'b0;
              state_reg <= RX_DATA;
              idx_reg   <= 3'h0;
              cnt_reg   <= BIT_9600 - 20'h00001;
            end else if (tick) begin
              cnt_reg <= period - 20'h00001;
              if (state_reg == RX_START) begin
                idx_reg   <= 3'h0;
                state_reg <= line ? RX_DATA : RX_IDLE;
                frame_err <= !line;
              end else if (state_reg == RX_DATA) begin
                // 0 V is the mark level, so a high line carries a zero
                shift_reg <= {~line, shift_reg[7:1]};
                idx_reg   <= idx_reg + 3'h1;
                if (idx_reg == 3'h7) begin
                  state_reg <= RX_STOP;
                end
              end else begin
                state_reg  <= RX_IDLE;
                byte_valid <= !line;
                byte_data  <= line ? byte_data : shift_reg;
                // a high stop bit means the rates do not match
                frame_err  <= line;
              end
            end else begin
              cnt_reg <= cnt_reg - 20'h00001;
            end
          end
        endcase
      end
    end
  end

  default clocking rx_cb @(posedge clk); endclocking
  default disable iff (rst);

  lock_holds_a: assert property ((decided_reg && gate) |=> $stable(fast_lock))
    else $error("fallback rate changed while gate high");
  gate_low_a: assert property (!gate |=> !byte_valid)
    else $error("byte delivered with gate low");
endmodule

// ### rtl/serial_capture_storage.sv
// serial capture and storage top: pin synchronisers, byte store, file marks,
// display, write and dump pointers, and the Wishbone register slave
// assumes a classic single-cycle Wishbone master and raw pins from the logger
//
// Implementation choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`include "capture_regs.svh"
module serial_capture_storage #(
  parameter logic [19:0] BIT_300   = 20'(`CLK_HZ / `BAUD_300),
  parameter logic [19:0] BIT_1200  = 20'(`CLK_HZ / `BAUD_1200),
  parameter logic [19:0] BIT_9600  = 20'(`CLK_HZ / `BAUD_9600),
  parameter logic [19:0] BIT_76800 = 20'(`CLK_HZ / `BAUD_76800)
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        serial_transmit_line,
  input  wire logic        capture_gate,
  input  wire logic        program_compiled,
  input  wire logic        keypad_mark,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o
);
  import capture_pkg::*;

  localparam int AW = `ADDR_W;

  logic [3:0]      s1_reg;
  logic [3:0]      s2_reg;
  logic [3:0]      prev_reg;
  logic [1:0]      settle_reg;
  logic            gate_armed_reg;
  logic [3:0]      ctrl_reg;
  logic [AW-1:0]   wptr_reg;
  logic [AW-1:0]   disp_ptr_reg;
  logic [AW-1:0]   dump_ptr_reg;
  logic            mark_pend_reg;
  logic            last_mark_reg;
  logic            dump_active_reg;
  logic            standby_reg;
  logic [`ERR_W-1:0] err_cnt_reg;
  logic [6:0]      elem_cnt_reg;
  logic            ack_reg;
  logic [31:0]     dat_reg;
  logic [9:0]      mem [0:`MEM_DEPTH-1];

  logic            rx_valid;
  logic [7:0]      rx_byte;
  logic            rx_err;
  logic            rx_fast;

  wire logic [3:0] pins = {keypad_mark, program_compiled, capture_gate,
                           serial_transmit_line};

  // every pin passes two flops before anything looks at it
  generate
    for (genvar i = 0; i < 4; i++) begin : g_sync
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          s1_reg[i] <= 1'b0;
          s2_reg[i] <= 1'b0;
        end else begin
          s1_reg[i] <= pins[i];
          s2_reg[i] <= s1_reg[i];
        end
      end
    end
  endgenerate

  // edges are ignored until the synchronisers hold real pin levels
  wire logic       settled = settle_reg == `SETTLE_DONE;
  wire logic [3:0] rise    = s2_reg & ~prev_reg & {4{settled}};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_reg   <= 4'h0;
      settle_reg <= 2'h0;
    end else begin
      prev_reg   <= s2_reg;
      settle_reg <= settled ? settle_reg : settle_reg + 2'h1;
    end
  end

  // a gate high at power-up counts only after it next rises
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gate_armed_reg <= 1'b0;
    end else if (rise[`PIN_GATE]) begin
      gate_armed_reg <= 1'b1;
    end
  end

  // capture only while the gate is high and armed
  wire logic capture_on = s2_reg[`PIN_GATE] & gate_armed_reg;

  capture_rx #(
    .BIT_300   (BIT_300),
    .BIT_1200  (BIT_1200),
    .BIT_9600  (BIT_9600),
    .BIT_76800 (BIT_76800)
  ) u_rx (
    .clk        (clk),
    .rst        (rst),
    .line       (s2_reg[`PIN_LINE]),
    .gate       (capture_on),
    .standby    (standby_reg),
    .rate       (rate_t'(ctrl_reg[2:0])),
    .byte_valid (rx_valid),
    .byte_data  (rx_byte),
    .frame_err  (rx_err),
    .fast_lock  (rx_fast)
  );

  // bus decode
  wire logic req      = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire logic wr       = req & wb_we_i & (wb_sel_i == 4'hF);
  wire logic rd       = req & ~wb_we_i;
  wire logic hit_ctrl = wb_adr_i == `ADR_CTRL;
  wire logic hit_stat = wb_adr_i == `ADR_STATUS;
  wire logic hit_cmd  = wb_adr_i == `ADR_CMD;
  wire logic hit_disp = wb_adr_i == `ADR_DISP;
  wire logic hit_wptr = wb_adr_i == `ADR_WPTR;
  wire logic hit_dptr = wb_adr_i == `ADR_DUMPPTR;
  wire logic hit_dump = wb_adr_i == `ADR_DUMPDATA;

  wire logic          cmd_wr     = wr & hit_cmd;
  wire logic          pos_cmd    = wr & hit_disp;
  wire logic          move_wptr  = wr & hit_wptr;
  wire logic          move_dptr  = wr & hit_dptr;
  wire logic          cmd_mark   = cmd_wr & wb_dat_i[`CMD_MARK];
  wire logic          cmd_dump   = cmd_wr & wb_dat_i[`CMD_DUMP];
  wire logic          cmd_resume = cmd_wr & wb_dat_i[`CMD_RESUME];
  wire logic          cmd_wake   = cmd_wr & wb_dat_i[`CMD_WAKE];
  wire logic [AW-1:0] bus_ptr    = wb_dat_i[AW-1:0];

  // storage side
  wire logic          byte_wr  = rx_valid;
  wire logic          encode   = ctrl_reg[`CTRL_ENC];
  // first point and every hundredth-plus-one point start an array
  wire logic          arr_tag  = encode & (elem_cnt_reg == 7'h00);
  // a pending mark is dropped when the last item is already a mark
  wire logic          mark_try = mark_pend_reg & ~byte_wr;
  wire logic          mark_wr  = mark_try & ~last_mark_reg;
  wire logic [AW-1:0] wptr_inc = wptr_reg + 12'h001;
  wire logic          store    = byte_wr | mark_wr;
  wire logic [9:0]    store_w  = byte_wr ? {1'b0, arr_tag, rx_byte} : 10'h200;

  // dump side
  wire logic [9:0]    mem_q    = mem[disp_ptr_reg];
  // a dump ends at the write pointer or at the next file mark
  wire logic          dump_end = (disp_ptr_reg == wptr_reg) | mem_q[9];
  wire logic          dump_ok  = dump_active_reg & ~dump_end;
  wire logic          dump_rd  = rd & hit_dump;
  wire logic [31:0]   dump_w   = {22'h000000, dump_ok, mem_q[8:0] & {9{dump_ok}}};

  wire logic [31:0] stat_w = {19'h00000, mark_pend_reg, rx_fast, dump_active_reg,
                              last_mark_reg, standby_reg, err_cnt_reg};

  wire logic [31:0] rd_word =
      hit_ctrl ? {28'h0000000, ctrl_reg} :
      hit_stat ? stat_w :
      hit_disp ? {20'h00000, disp_ptr_reg} :
      hit_wptr ? {20'h00000, wptr_reg} :
      hit_dptr ? {20'h00000, dump_ptr_reg} :
      hit_dump ? dump_w : 32'h00000000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else begin
      ack_reg <= req;
      if (req) begin
        dat_reg <= wb_we_i ? 32'h00000000 : rd_word;
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // rate and encode setting, reset to combined mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= `CTRL_RESET;
    end else if (wr & hit_ctrl) begin
      ctrl_reg <= wb_dat_i[3:0];
    end
  end

  // with encoding off the byte is stored as received
  always_ff @(posedge clk) begin
    if (store) begin
      mem[wptr_reg] <= store_w;
    end
  end

  // write pointer follows the data, a move makes it overwrite
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wptr_reg <= 12'h000;
    end else if (move_wptr) begin
      wptr_reg <= bus_ptr;
    end else if (store) begin
      wptr_reg <= wptr_inc;
    end
  end

  // pending from reset; compile; keypad or host; set wins
  wire logic mark_set = rise[`PIN_COMPILE] | rise[`PIN_KEYPAD] | cmd_mark;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mark_pend_reg <= 1'b1;
      last_mark_reg <= 1'b0;
    end else begin
      mark_pend_reg <= mark_set | (mark_pend_reg & ~mark_try);
      if (byte_wr) begin
        last_mark_reg <= 1'b0;
      end else if (mark_wr) begin
        last_mark_reg <= 1'b1;
      end
    end
  end

  // element counter restarts with each gate rise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      elem_cnt_reg <= 7'h00;
    end else if (rise[`PIN_GATE]) begin
      elem_cnt_reg <= 7'h00;
    end else if (byte_wr & encode) begin
      elem_cnt_reg <= (elem_cnt_reg == `ARRAY_LAST) ? 7'h00 : elem_cnt_reg + 7'h01;
    end
  end

  // display pointer: position command, new file start, dump walk
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      disp_ptr_reg <= 12'h000;
    end else if (pos_cmd) begin
      disp_ptr_reg <= bus_ptr;
    end else if (mark_wr & ~move_wptr) begin
      disp_ptr_reg <= wptr_inc;
    end else if (cmd_resume) begin
      disp_ptr_reg <= dump_ptr_reg;
    end else if (dump_rd & dump_ok) begin
      disp_ptr_reg <= disp_ptr_reg + 12'h001;
    end
  end

  // dump runs until a read finds its end
  // the end point becomes the next dump start
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dump_active_reg <= 1'b0;
      dump_ptr_reg    <= 12'h000;
    end else begin
      if (cmd_dump | cmd_resume) begin
        dump_active_reg <= 1'b1;
      end else if (dump_rd & dump_active_reg & dump_end) begin
        dump_active_reg <= 1'b0;
      end
      if (move_dptr) begin
        dump_ptr_reg <= bus_ptr;
      end else if (dump_rd & dump_active_reg & dump_end) begin
        dump_ptr_reg <= disp_ptr_reg;
      end
    end
  end

  // mismatch counts and sends the receiver to standby; set wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_cnt_reg <= 8'h00;
      standby_reg <= 1'b0;
    end else begin
      err_cnt_reg <= err_cnt_reg + {7'h00, rx_err};
      standby_reg <= rx_err | (standby_reg & ~cmd_wake);
    end
  end

  default clocking top_cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence bus_req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  bus_ack_a: assert property (bus_req_s |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle after request");
  rate_reset_a: assert property (settle_reg == 2'h0 |-> ctrl_reg[2:0] == RATE_AUTO)
    else $error("rate not combined mode after reset");
  power_mark_a: assert property ((settle_reg == 2'h0 && !byte_wr) |-> mark_wr)
    else $error("no file mark at power up");
  mark_store_a: assert property ((mark_wr && !move_wptr) |=>
      last_mark_reg && wptr_reg == $past(wptr_reg) + 12'h001)
    else $error("file mark not stored");
  no_repeat_a: assert property ((last_mark_reg && !byte_wr && !move_wptr) |=>
      wptr_reg == $past(wptr_reg))
    else $error("back to back file mark stored");
  byte_store_a: assert property ((byte_wr && !move_wptr) |=>
      !last_mark_reg && wptr_reg == $past(wptr_reg) + 12'h001)
    else $error("byte did not advance write pointer");
  armed_gate_a: assert property (!gate_armed_reg |-> !byte_wr)
    else $error("byte stored before gate rose");
  err_standby_a: assert property (rx_err |=>
      standby_reg && err_cnt_reg == $past(err_cnt_reg) + 8'h01)
    else $error("rate error not counted");
  dump_stop_a: assert property ((dump_rd && dump_active_reg && dump_end) |=>
      !dump_active_reg && dump_ptr_reg == $past(disp_ptr_reg))
    else $error("dump end not recorded");
  dump_step_a: assert property ((dump_rd && dump_ok && !mark_wr) |=>
      disp_ptr_reg == $past(disp_ptr_reg) + 12'h001 ##1 wb_dat_o[9])
    else $error("dump did not advance");
endmodule

// ### verif/logger_model.sv
// sender standing in for the logger's serial transmit pin
// assumes the bench calls send() from its main sequence, one frame at a time
`timescale 1ns/1ps
module logger_model (
  input  wire logic clk,
  output logic      line
);
  // line rests at its idle level between frames
  initial line = 1'b0;

  task automatic bit_out(input logic v, input int n);
    @(posedge clk);
    line <= v;
    repeat (n - 1) @(posedge clk);
  endtask

  // caller picks rate, start high, inverted data lsb first, stop low
  task automatic send(input logic [7:0] b, input int n);
    bit_out(1'b1, n);
    for (int i = 0; i < 8; i++) begin
      bit_out(~b[i], n);
    end
    bit_out(1'b0, n);
    repeat (n) @(posedge clk);
  endtask
endmodule

// ### verif/serial_capture_storage_tb.sv
// self-checking bench for the capture and storage block
// assumes shortened bit counts so every rate fits in a few hundred cycles
`timescale 1ns/1ps
module serial_capture_storage_tb;
  localparam int B300 = 64;
  localparam int B1200 = 32;
  localparam int B9600 = 40;
  localparam int B76800 = 4;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic        clk = 1'b0, rst = 1'b1, gate = 1'b1, comp = 1'b0, key = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, line;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, q, dat_o;
  logic [31:0] exp_w [6] = '{32'h230, 32'h231, 32'h232, 32'h233, 32'h355, 32'h366};
  int          fail_count = 0, cmp_count = 0, cycles = 0, w;
  int          per [4] = '{B300, B1200, B9600, B76800};

  serial_capture_storage #(
    .BIT_300(20'(B300)), .BIT_1200(20'(B1200)),
    .BIT_9600(20'(B9600)), .BIT_76800(20'(B76800))
  ) uut (
    .clk(clk), .rst(rst), .serial_transmit_line(line), .capture_gate(gate),
    .program_compiled(comp), .keypad_mark(key), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF),
    .wb_dat_o(dat_o), .wb_ack_o(ack)
  );
  logger_model lg (.clk(clk), .line(line));

  always #2 clk = ~clk;

  task automatic close_out();
    $display("mismatches %0d comparisons %0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // a hang ends the run as a mismatch
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    cmp_count++;
    if ((q & m) !== e) begin
      fail_count++;
      $display("[ERR] %0t adr %h got %h expected %h", $time, a, q & m, e);
    end
  endtask

  // capture only arms on a fresh gate rise
  task automatic regate();
    gate <= 1'b0;
    repeat (8) @(posedge clk);
    gate <= 1'b1;
    repeat (8) @(posedge clk);
  endtask

  task automatic mark(input int s);
    if (s == 0) begin
      wb(1'b1, 8'h08, 32'h1);
    end else begin
      if (s == 1)
        key <= 1'b1;
      else
        comp <= 1'b1;
      repeat (8) @(posedge clk);
      key <= 1'b0;
      comp <= 1'b0;
    end
    repeat (12) @(posedge clk);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(8'h00, ALL, 32'hC);  // default rate setting
    rd(8'h10, ALL, 32'h1);  // power-up mark written
    rd(8'h04, 32'h200, 32'h200);  // last item a mark
    rd(8'h40, ALL, 32'h0);  // unmapped place reads zero
    lg.send(8'h11, B9600);  // gate high since power-up
    rd(8'h10, ALL, 32'h1);  // nothing stored
    for (int r = 0; r < 4; r++) begin
      wb(1'b1, 8'h00, 32'(r));
      regate();
      lg.send(8'h30 + 8'(r), per[r]);
      rd(8'h10, ALL, 32'(r + 2));  // byte stored at each rate
    end
    wb(1'b1, 8'h00, 32'h1);
    regate();
    lg.send(8'h00, B300);  // sender rate wrong on purpose
    rd(8'h04, 32'h1FF, 32'h101);  // error count and standby
    rd(8'h10, ALL, 32'h5);  // nothing stored
    wb(1'b1, 8'h08, 32'h8);
    rd(8'h04, 32'h100, 32'h0);  // standby left
    wb(1'b1, 8'h00, 32'hC);
    regate();
    lg.send(8'h55, B76800);
    rd(8'h04, 32'h800, 32'h800);  // fast rate chosen
    regate();
    lg.send(8'h66, B9600);
    rd(8'h04, 32'h800, 32'h0);  // fell back to slow rate
    rd(8'h10, ALL, 32'h7);  // both bytes stored
    w = 7;
    for (int s = 0; s < 3; s++) begin
      mark(s);
      rd(8'h10, ALL, 32'(w + 1));  // mark from each source
      rd(8'h0C, ALL, 32'(w + 1));  // display at file start
      mark(s);
      rd(8'h10, ALL, 32'(w + 1));  // second mark refused
      lg.send(8'h70, B9600);
      w = w + 2;
    end
    rd(8'h10, ALL, 32'hD);  // pointer at data end
    wb(1'b1, 8'h0C, 32'h1);
    wb(1'b1, 8'h08, 32'h2);
    for (int i = 0; i < 6; i++) begin
      rd(8'h18, ALL, exp_w[i]);  // dumped words and tags
    end
    rd(8'h18, ALL, 32'h0);  // dump stops at mark
    rd(8'h14, ALL, 32'h7);  // dump end remembered
    wb(1'b1, 8'h10, 32'h1);
    wb(1'b1, 8'h00, 32'h2);
    regate();
    lg.send(8'hA5, B9600);
    rd(8'h10, ALL, 32'h2);  // write pointer moved
    wb(1'b1, 8'h14, 32'h1);
    wb(1'b1, 8'h08, 32'h4);
    rd(8'h18, ALL, 32'h2A5);  // overwrite seen from dump pointer
    rd(8'h18, ALL, 32'h0);  // dump stops at write pointer
    wb(1'b1, 8'h00, 32'hB);
    regate();
    for (int i = 0; i < 101; i++) begin
      lg.send(8'(i), B76800);  // one array of 100 points and the first point of the next
    end
    rd(8'h10, ALL, 32'h67);  // all points stored
    wb(1'b1, 8'h0C, 32'h65);
    wb(1'b1, 8'h08, 32'h2);
    rd(8'h04, 32'h400, 32'h400);  // dump running
    rd(8'h18, ALL, 32'h263);  // hundredth point untagged
    rd(8'h18, ALL, 32'h364);  // next point starts an array
    close_out();
  end
endmodule
